// ### common/temp_thermo_pkg.sv
// Purpose: Constants and types for the temperature conversion and thermostat block
// Assumes: 40 MHz core clock, 32-bit Avalon-MM register access at byte offsets
// Notes: Times are kept in their own unit and turned into cycle counts here
package temp_thermo_pkg;
  localparam int CLK_KHZ = 40000;
  localparam int CONV_TIME_MS = 750;
  localparam int CONV_CYCLES = CONV_TIME_MS * CLK_KHZ;
  localparam int NV_WRITE_MS = 10;
  localparam int NV_CYCLES = NV_WRITE_MS * CLK_KHZ;

  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_CFG = 5'h04;
  localparam logic [4:0] OFS_TEMP = 5'h08;
  localparam logic [4:0] OFS_HIGH = 5'h0c;
  localparam logic [4:0] OFS_LOW = 5'h10;
  localparam logic [4:0] OFS_REMAIN = 5'h14;
  localparam logic [4:0] OFS_SLOPE = 5'h18;
  localparam logic [4:0] OFS_STATUS = 5'h1c;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CFG_HIGH_BIT = 6;
  localparam int CFG_LOW_BIT = 5;
  localparam int CFG_POL_BIT = 1;
  localparam int CFG_ONESHOT_BIT = 0;
  localparam int HALF_BIT = 7;

  localparam logic [8:0] TEMP_MIN = 9'h192;
  localparam logic [8:0] TEMP_MAX = 9'h0fa;
  localparam logic [8:0] HIGH_RST = 9'h050;
  localparam logic [8:0] LOW_RST = 9'h03c;
  localparam logic POL_RST = 1'b1;
  localparam logic ONESHOT_RST = 1'b0;

  typedef struct packed {
    logic done;
    logic high_seen;
    logic low_seen;
    logic nv_busy;
    logic [1:0] rsv;
    logic polarity;
    logic one_shot;
  } cfg_t;

  typedef struct packed {
    logic [8:0] temp;
    logic [7:0] remain;
    logic [7:0] slope;
  } sense_t;

  typedef enum logic {st_idle, st_convert} conv_state_t;
endpackage

// ### rtl/temp_conv_thermostat.sv
// Purpose: Conversion control, reading registers and thermostat with hysteresis
// Assumes: Sensor front end presents a settled result on i_sense
// Notes: One Avalon-MM slave answers each request after exactly one wait cycle
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module temp_conv_thermostat #(
  parameter int CONV_CYCLES = temp_thermo_pkg::CONV_CYCLES,
  parameter int NV_CYCLES = temp_thermo_pkg::NV_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Sensor front end
  input wire temp_thermo_pkg::sense_t i_sense,
  output logic o_sense_en,
  // Thermostat pin
  output logic o_tout
);

  localparam int CNT_W = $clog2(CONV_CYCLES + 1);
  localparam int NV_W = $clog2(NV_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [NV_W-1:0] NV_LOAD = NV_W'(NV_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic wait_ff;
  logic [31:0] rdata_ff;
  temp_thermo_pkg::sense_t sense_meta_ff;
  temp_thermo_pkg::sense_t sense_sync_ff;
  temp_thermo_pkg::conv_state_t state_ff;
  temp_thermo_pkg::conv_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [8:0] temp_ff;
  logic [7:0] remain_ff;
  logic [7:0] slope_ff;
  logic [8:0] high_ff;
  logic [8:0] low_ff;
  logic pol_ff;
  logic one_shot_ff;
  logic done_ff;
  logic high_seen_ff;
  logic low_seen_ff;
  logic active_ff;
  logic [NV_W-1:0] nv_cnt_ff;
  logic tout_ff;
  logic sense_en_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire req = i_avs_read | i_avs_write;
  wire wr_acc = i_avs_write & ~wait_ff;
  wire rd_load = i_avs_read & wait_ff;
  wire nxt_wait = ~(req & wait_ff);
  wire [31:0] wd = i_avs_writedata;
  wire [3:0] be = i_avs_byteenable;
  wire wr_ctrl = wr_acc & (i_avs_address == temp_thermo_pkg::OFS_CTRL) & be[0];
  wire wr_cfg = wr_acc & (i_avs_address == temp_thermo_pkg::OFS_CFG) & be[0];
  wire wr_high = wr_acc & (i_avs_address == temp_thermo_pkg::OFS_HIGH);
  wire wr_low = wr_acc & (i_avs_address == temp_thermo_pkg::OFS_LOW);
  wire start_cmd = wr_ctrl & wd[temp_thermo_pkg::CTRL_START_BIT];
  wire stop_cmd = wr_ctrl & wd[temp_thermo_pkg::CTRL_STOP_BIT];
  wire clr_high = wr_cfg & ~wd[temp_thermo_pkg::CFG_HIGH_BIT];
  wire clr_low = wr_cfg & ~wd[temp_thermo_pkg::CFG_LOW_BIT];

  // Threshold write: upper lane whole degrees, lower lane the half bit
  wire [8:0] high_wr = be[1] ? {wd[15:8], be[0] & wd[temp_thermo_pkg::HALF_BIT]}
                             : {high_ff[8:1], wd[temp_thermo_pkg::HALF_BIT]};
  wire [8:0] low_wr = be[1] ? {wd[15:8], be[0] & wd[temp_thermo_pkg::HALF_BIT]}
                            : {low_ff[8:1], wd[temp_thermo_pkg::HALF_BIT]};
  wire high_load = wr_high & (be[1] | be[0]);
  wire low_load = wr_low & (be[1] | be[0]);
  wire nv_write = high_load | low_load | wr_cfg;
  wire nv_busy = nv_cnt_ff != '0;

  ////////////////////////////////////////////////////////////////////////////
  // Read selection
  temp_thermo_pkg::cfg_t cfg_rd;
  assign cfg_rd = '{done: done_ff, high_seen: high_seen_ff, low_seen: low_seen_ff,
                    nv_busy: nv_busy, rsv: 2'b00, polarity: pol_ff,
                    one_shot: one_shot_ff};
  // Left-justified: whole degrees in the upper byte, half bit on top of lower
  wire [15:0] temp16 = {temp_ff, 7'h00};
  wire [15:0] high16 = {high_ff, 7'h00};
  wire [15:0] low16 = {low_ff, 7'h00};
  wire [31:0] rd_word =
    (i_avs_address == temp_thermo_pkg::OFS_CFG) ? {24'h000000, cfg_rd} :
    (i_avs_address == temp_thermo_pkg::OFS_TEMP) ? {16'h0000, temp16} :
    (i_avs_address == temp_thermo_pkg::OFS_HIGH) ? {16'h0000, high16} :
    (i_avs_address == temp_thermo_pkg::OFS_LOW) ? {16'h0000, low16} :
    (i_avs_address == temp_thermo_pkg::OFS_REMAIN) ? {24'h000000, remain_ff} :
    (i_avs_address == temp_thermo_pkg::OFS_SLOPE) ? {24'h000000, slope_ff} :
    (i_avs_address == temp_thermo_pkg::OFS_STATUS) ?
      {30'h00000000, active_ff, state_ff == temp_thermo_pkg::st_convert} :
    32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  wire converting = state_ff == temp_thermo_pkg::st_convert;
  wire conv_done = converting & (cnt_ff == CNT_LAST);

  always_comb begin
    nxt_state = state_ff;
    if (start_cmd) begin
      nxt_state = temp_thermo_pkg::st_convert;
    end else if (stop_cmd) begin
      nxt_state = temp_thermo_pkg::st_idle;
    end else if (conv_done & one_shot_ff) begin
      nxt_state = temp_thermo_pkg::st_idle;
    end
  end

  // Continuous mode wraps the counter and carries on
  assign nxt_cnt = (start_cmd | conv_done | ~converting) ? '0 : cnt_ff + 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Result capture and thermostat decision
  wire signed [8:0] raw_s = $signed(sense_sync_ff.temp);
  wire below_min = raw_s < $signed(temp_thermo_pkg::TEMP_MIN);
  wire above_max = raw_s > $signed(temp_thermo_pkg::TEMP_MAX);
  wire [8:0] samp_temp = below_min ? temp_thermo_pkg::TEMP_MIN :
                         above_max ? temp_thermo_pkg::TEMP_MAX : sense_sync_ff.temp;
  wire ge_high = $signed(samp_temp) >= $signed(high_ff);
  wire lt_low = $signed(samp_temp) < $signed(low_ff);
  wire le_low = $signed(samp_temp) <= $signed(low_ff);
  // High trip dominates when thresholds overlap
  wire nxt_active = conv_done ? (ge_high | (active_ff & ~lt_low)) : active_ff;
  wire nxt_high_seen = (high_seen_ff & ~clr_high) | (conv_done & ge_high);
  wire nxt_low_seen = (low_seen_ff & ~clr_low) | (conv_done & le_low);
  wire nxt_done = start_cmd ? 1'b0 : (conv_done | stop_cmd) ? 1'b1 : done_ff;
  wire nxt_tout = active_ff ^ ~pol_ff;
  wire [NV_W-1:0] nxt_nv = nv_write ? NV_LOAD : nv_busy ? nv_cnt_ff - 1'b1 : nv_cnt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      wait_ff <= nxt_wait;
      if (rd_load) begin
        rdata_ff <= rd_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sensor input synchroniser
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sense_meta_ff <= '0;
      sense_sync_ff <= '0;
    end else begin
      sense_meta_ff <= i_sense;
      sense_sync_ff <= sense_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion state
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= temp_thermo_pkg::st_idle;
      cnt_ff <= '0;
      done_ff <= 1'b1;
      sense_en_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
      sense_en_ff <= nxt_state == temp_thermo_pkg::st_convert;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      temp_ff <= 9'h000;
      remain_ff <= 8'h00;
      slope_ff <= 8'h00;
    end else if (conv_done) begin
      temp_ff <= samp_temp;
      remain_ff <= sense_sync_ff.remain;
      slope_ff <= sense_sync_ff.slope;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings held as nonvolatile copies
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      high_ff <= temp_thermo_pkg::HIGH_RST;
      low_ff <= temp_thermo_pkg::LOW_RST;
      pol_ff <= temp_thermo_pkg::POL_RST;
      one_shot_ff <= temp_thermo_pkg::ONESHOT_RST;
      nv_cnt_ff <= '0;
    end else begin
      nv_cnt_ff <= nxt_nv;
      if (high_load) begin
        high_ff <= high_wr;
      end
      if (low_load) begin
        low_ff <= low_wr;
      end
      if (wr_cfg) begin
        pol_ff <= wd[temp_thermo_pkg::CFG_POL_BIT];
        one_shot_ff <= wd[temp_thermo_pkg::CFG_ONESHOT_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermostat and flags
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      active_ff <= 1'b0;
      high_seen_ff <= 1'b0;
      low_seen_ff <= 1'b0;
      tout_ff <= ~temp_thermo_pkg::POL_RST;
    end else begin
      active_ff <= nxt_active;
      high_seen_ff <= nxt_high_seen;
      low_seen_ff <= nxt_low_seen;
      tout_ff <= nxt_tout;
    end
  end

  assign o_avs_waitrequest = wait_ff;
  assign o_avs_readdata = rdata_ff;
  assign o_sense_en = sense_en_ff;
  assign o_tout = tout_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  bus_answer_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");

  rd_data_a: assert property (i_avs_read && o_avs_waitrequest |=>
                               o_avs_readdata == $past(rd_word))
    else $error("read data does not match selected register");

  temp_word_a: assert property (i_avs_read && o_avs_waitrequest &&
                                 i_avs_address == temp_thermo_pkg::OFS_TEMP |=>
                                 o_avs_readdata[31:16] == 16'h0000 &&
                                 o_avs_readdata[6:0] == 7'h00)
    else $error("reading word carries bits outside its 16-bit form");

  temp_range_a: assert property ($signed(temp_ff) >= $signed(temp_thermo_pkg::TEMP_MIN) &&
                                  $signed(temp_ff) <= $signed(temp_thermo_pkg::TEMP_MAX))
    else $error("reading outside measurement span");

  idle_hold_a: assert property (!converting && !start_cmd |=> !converting)
    else $error("conversion began without a begin command");

  start_run_a: assert property (start_cmd |=> converting && cnt_ff == '0 && !done_ff)
    else $error("begin command did not start a fresh conversion");

  halt_idle_a: assert property (stop_cmd && !start_cmd |=> !converting ##1 !converting)
    else $error("halt did not return to idle");

  one_shot_a: assert property (conv_done && one_shot_ff && !start_cmd |=>
                                !converting && done_ff && temp_ff == $past(samp_temp))
    else $error("one-shot did not stop after one conversion");

  cont_run_a: assert property (conv_done && !one_shot_ff && !stop_cmd |=>
                                converting && cnt_ff == '0)
    else $error("continuous mode did not restart");

  active_hold_a: assert property (!conv_done |=> active_ff == $past(active_ff))
    else $error("thermostat changed outside a conversion end");

  trip_high_a: assert property (conv_done && ge_high |=> active_ff && high_seen_ff)
    else $error("thermostat or flag not set at high threshold");

  trip_low_a: assert property (conv_done && lt_low && !ge_high |=> !active_ff)
    else $error("thermostat not released below low threshold");

  pin_level_a: assert property (##1 o_tout == ($past(active_ff) ^ ~$past(pol_ff)))
    else $error("thermostat pin level wrong for polarity");

  flag_sticky_a: assert property (high_seen_ff && !clr_high |=> high_seen_ff)
    else $error("high flag dropped without a clearing write");

  oneshot_cv: cover property (start_cmd && one_shot_ff ##1 converting [*3]);
  cont_cv: cover property (conv_done && !one_shot_ff ##1 converting);
  trip_cv: cover property (conv_done && ge_high ##1 o_tout == pol_ff);
  halt_cv: cover property (converting && stop_cmd ##1 !converting);

endmodule // temp_conv_thermostat

// ### test/cmd_master.sv
// Purpose: Command master model on the register bus of the sensor block
// Assumes: One request at a time, each held until waitrequest is seen low
// Notes: o_hang rises when an answer never comes
`timescale 1ns/1ps
module cmd_master (
  // Clock
  input wire logic i_core_clk,
  // Avalon-MM master side
  output logic [4:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [3:0] o_byteenable,
  output logic [31:0] o_writedata,
  input wire logic [31:0] i_readdata,
  input wire logic i_waitrequest,
  // Status
  output logic o_hang
);
  initial begin
    o_address = 5'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_byteenable = 4'h0;
    o_writedata = 32'h0;
    o_hang = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One bus cycle; byte lanes pick one-byte or two-byte values
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge i_core_clk);
    o_address <= a;
    o_byteenable <= be;
    o_writedata <= d;
    o_read <= !wr;
    o_write <= wr;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (i_waitrequest !== 1'b0 && n < 50);
    q = i_readdata;
    if (i_waitrequest !== 1'b0) o_hang <= 1'b1;
    o_read <= 1'b0;
    o_write <= 1'b0;
    // Released data must not keep showing the last value
    o_writedata <= ~d;
  endtask
endmodule // cmd_master

// ### test/temp_conversion_thermostat_bench.sv
// Purpose: Self-checking bench for conversion control and thermostat
// Assumes: Short conversion count, one-shot rows then hand-written cases
// Notes: Expected values come from the reading format and trip rules
`timescale 1ns/1ps
module temp_conversion_thermostat_bench;
  localparam int CONV = 20;
  typedef struct packed {logic [8:0] temp; logic [15:0] word; logic act;} row_t;
  logic clk, rst_b, rd_s, wr_s, waitreq, sense_en, tout, hang;
  logic [4:0] address;
  logic [3:0] be;
  logic [31:0] wdata, rdata, q;
  temp_thermo_pkg::sense_t sense;
  int n_mismatch = 0;
  int checked = 0;
  row_t rows[9] = '{'{9'h0fa, 16'h7d00, 1'b1}, '{9'h1ff, 16'hff80, 1'b0},
    '{9'h050, 16'h2800, 1'b1}, '{9'h03c, 16'h1e00, 1'b1}, '{9'h03b, 16'h1d80, 1'b0},
    '{9'h192, 16'hc900, 1'b0}, '{9'h032, 16'h1900, 1'b0}, '{9'h100, 16'hc900, 1'b0},
    '{9'h001, 16'h0080, 1'b0}};

  temp_conv_thermostat #(.CONV_CYCLES(CONV), .NV_CYCLES(8)) dut (.i_core_clk(clk),
    .i_rst_b(rst_b), .i_avs_address(address), .i_avs_read(rd_s), .i_avs_write(wr_s),
    .i_avs_byteenable(be), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_sense(sense), .o_sense_en(sense_en), .o_tout(tout));
  cmd_master master (.i_core_clk(clk), .o_address(address), .o_read(rd_s), .o_write(wr_s),
    .o_byteenable(be), .o_writedata(wdata), .i_readdata(rdata),
    .i_waitrequest(waitreq), .o_hang(hang));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    master.xfer(1'b1, a, 4'hf, d, x);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] x);
    master.xfer(1'b0, a, 4'hf, 32'h0, x);
  endtask
  // Begin one conversion and poll done under a bound
  task automatic conv();
    int n;
    logic [31:0] x;
    wr(temp_thermo_pkg::OFS_CTRL, 32'h1);
    n = 0;
    do begin
      rd(temp_thermo_pkg::OFS_CFG, x);
      n++;
    end while (x[7] !== 1'b1 && n < 40);
    if (x[7] !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    repeat (2) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge hang) begin
    n_mismatch++;
    conclude();
  end

  initial begin
    rst_b = 1'b0;
    sense = '0;
    repeat (10) @(posedge clk);
    chk_b(waitreq, 1'b1);
    chk_b(tout, 1'b0);
    rst_b <= 1'b1;
    rd(temp_thermo_pkg::OFS_CFG, q);
    chk_w(q[15:0], 16'h0082);
    rd(temp_thermo_pkg::OFS_HIGH, q);
    chk_w(q[15:0], 16'h2800);
    rd(temp_thermo_pkg::OFS_LOW, q);
    chk_w(q[15:0], 16'h1e00);
    rd(temp_thermo_pkg::OFS_CTRL, q);
    chk_w(q[15:0], 16'h0000);
    repeat (30) @(posedge clk);
    chk_b(sense_en, 1'b0);
    // Rows: one-shot conversions across the span
    wr(temp_thermo_pkg::OFS_CFG, 32'h03);
    rd(temp_thermo_pkg::OFS_CFG, q);
    chk_b(q[4], 1'b1);
    foreach (rows[i]) begin
      sense <= '{temp: rows[i].temp, remain: 8'h10 + 8'(i), slope: 8'h40};
      conv();
      rd(temp_thermo_pkg::OFS_TEMP, q);
      chk_w(q[15:0], rows[i].word);
      master.xfer(1'b0, temp_thermo_pkg::OFS_TEMP, 4'h2, 32'h0, q);
      chk_w({8'h00, q[15:8]}, {8'h00, rows[i].word[15:8]});
      chk_b(tout, rows[i].act);
      chk_b(sense_en, 1'b0);
      rd(temp_thermo_pkg::OFS_REMAIN, q);
      chk_w(q[15:0], 16'h0010 + 16'(i));
    end
    rd(temp_thermo_pkg::OFS_SLOPE, q);
    chk_w(q[15:0], 16'h0040);
    repeat (50) @(posedge clk);
    chk_b(tout, 1'b0);
    // Negative thresholds, whole-degree write
    master.xfer(1'b1, temp_thermo_pkg::OFS_HIGH, 4'h2, 32'hff80, q);
    rd(temp_thermo_pkg::OFS_HIGH, q);
    chk_w(q[15:0], 16'hff00);
    master.xfer(1'b1, temp_thermo_pkg::OFS_HIGH, 4'h1, 32'h80, q);
    rd(temp_thermo_pkg::OFS_HIGH, q);
    chk_w(q[15:0], 16'hff80);
    wr(temp_thermo_pkg::OFS_LOW, 32'hfe00);
    wr(temp_thermo_pkg::OFS_CFG, 32'h03);
    sense <= '{temp: 9'h1ff, remain: 8'h00, slope: 8'h40};
    conv();
    chk_b(tout, 1'b1);
    rd(temp_thermo_pkg::OFS_CFG, q);
    chk_b(q[6], 1'b1);
    wr(temp_thermo_pkg::OFS_CFG, 32'h03);
    sense <= '{temp: 9'h1fb, remain: 8'h00, slope: 8'h40};
    conv();
    chk_b(tout, 1'b0);
    rd(temp_thermo_pkg::OFS_CFG, q);
    chk_b(q[6], 1'b0);
    chk_b(q[5], 1'b1);
    // Active low pin
    wr(temp_thermo_pkg::OFS_CFG, 32'h01);
    repeat (2) @(posedge clk);
    chk_b(tout, 1'b1);
    sense <= '{temp: 9'h0fa, remain: 8'h00, slope: 8'h40};
    wr(temp_thermo_pkg::OFS_CTRL, 32'h1);
    rd(temp_thermo_pkg::OFS_CFG, q);
    chk_b(q[7], 1'b0);
    chk_b(sense_en, 1'b1);
    chk_b(tout, 1'b1);
    repeat (CONV) @(posedge clk);
    chk_b(tout, 1'b0);
    // Continuous mode, halt and restart
    wr(temp_thermo_pkg::OFS_CFG, 32'h00);
    wr(temp_thermo_pkg::OFS_CTRL, 32'h1);
    repeat (3 * CONV) @(posedge clk);
    chk_b(sense_en, 1'b1);
    rd(temp_thermo_pkg::OFS_STATUS, q);
    chk_w(q[15:0], 16'h0003);
    wr(temp_thermo_pkg::OFS_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    chk_b(sense_en, 1'b0);
    rd(temp_thermo_pkg::OFS_CFG, q);
    chk_b(q[7], 1'b1);
    // Begin and halt together: begin wins
    wr(temp_thermo_pkg::OFS_CTRL, 32'h3);
    repeat (2 * CONV) @(posedge clk);
    chk_b(sense_en, 1'b1);
    rd(temp_thermo_pkg::OFS_TEMP, q);
    chk_w(q[15:0], 16'h7d00);
    conclude();
  end
endmodule // temp_conversion_thermostat_bench
